// *** rtl/pm_clock_divider.sv ***
`timescale 1ns/1ps
// What this block does
// - normal rate: one machine cycle per four clocks
// - reduced modes divide by 64 or 1024
// - only software writes enter reduced modes
// - divider code 01=4, 10=64, 11=1024
// - new divider applies one machine cycle later
// - divided tick clocks every function outside idle, timers too
// - reduced codes accepted only from 4-clock state
// - hardware switchback only when enable bit set
// - enabled external interrupt triggers switchback
// - receiver start-bit edge triggers switchback
// - transmit buffer write triggers switchback
// - interrupt must be takeable to trigger switchback
// - ring source and crystal shutdown supported
// - divider and source are independent controls
// - idle peripherals tick at clock divided four
// - source select bit, read-only active status
// - crystal disable allowed only on ring
// - crystal ready after warm-up gates crystal select
// - switchback restores divider only, not source
module pm_clock_divider
  import pm_clock_pkg::*;
#(
  parameter int WARMUP_CLOCKS = XTAL_WARMUP_CLOCKS
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       clkEn,
  // special-function register port from the core
  input  wire logic [7:0] sfrAddr,
  input  wire logic [7:0] sfrWrData,
  input  wire logic       sfrWrite,
  input  wire logic       sfrRead,
  output logic      [7:0] sfrRdData,
  // core state
  input  wire logic       idleMode,
  // interrupt controller: per-source request already gated by enable and priority
  input  wire logic       extIntTakeable,
  input  wire logic       pfInService,
  input  wire logic       hiInService,
  input  wire logic       loInService,
  // serial ports (same clock domain)
  input  wire logic       rxStartEdge,
  input  wire logic       txBufferWrite,
  input  wire logic [3:0] serialActivity,
  // clock tree controls
  output logic            machineTick,
  output logic            peripheralTick,
  output logic            ringSelected,
  output logic            crystalAmpOff,
  output logic [1:0]      dividerActive
);

  // divider state
  logic [1:0] divSelect;        // software-visible divider field
  logic [1:0] next_divSelect;
  logic [1:0] divApplied;       // code the counter really uses
  logic [1:0] next_divApplied;
  logic       pendingApply;     // new code waits for cycle boundary
  logic       next_pendingApply;
  logic [9:0] cycleCnt;         // clocks within a machine cycle
  logic [9:0] next_cycleCnt;
  logic [1:0] fourCnt;          // fixed divide-by-4 for idle peripherals
  logic [1:0] next_fourCnt;
  // control bits
  logic       switchbackEnable;
  logic       next_switchbackEnable;
  logic       srcSelect;        // 1 crystal, 0 ring
  logic       next_srcSelect;
  logic       srcActive;        // 1 while ring runs the core
  logic       next_srcActive;
  logic       xtalOff;
  logic       next_xtalOff;
  logic       xtalReady;
  logic       next_xtalReady;
  logic [16:0] warmCnt;         // wide enough for the default warm-up
  logic [16:0] next_warmCnt;
  // output flops
  logic       next_machineTick;
  logic       next_peripheralTick;
  logic [7:0] next_sfrRdData;

  // helper terms
  // decodes kept combinational; they only feed registers
  logic       cycleEnd;
  logic [9:0] cycleLast;
  logic       hwSwitchback;
  logic       wrPower;
  logic       wrFlags;

  // code to cycle length
  // last count value of the current machine cycle; the reserved code never
  // reaches divApplied, so the default arm serves the 4-clock code only
  always_comb begin
    case (divApplied)
      DIV_64:   cycleLast = 10'(CLK_PER_CYCLE_64 - 1);
      DIV_1024: cycleLast = 10'(CLK_PER_CYCLE_1024 - 1);
      default:  cycleLast = 10'(CLK_PER_CYCLE_4 - 1);
    endcase
  end

  // machine-cycle boundary and register write decodes
  assign cycleEnd = (cycleCnt == cycleLast);
  assign wrPower  = sfrWrite && (sfrAddr == ADDR_POWER_MGMT);
  assign wrFlags  = sfrWrite && (sfrAddr == ADDR_EXT_INT_FLAGS);
  // hardware exit; interrupt input already reflects enable and priority
  // enable gate
  assign hwSwitchback = switchbackEnable && (extIntTakeable || rxStartEdge || txBufferWrite);

  // divider control and cycle counter
  // every field except cycleCnt and fourCnt holds unless a write, a trigger or a boundary moves it
  always_comb begin
    next_divSelect        = divSelect;
    next_divApplied       = divApplied;
    next_pendingApply     = pendingApply;
    next_switchbackEnable = switchbackEnable;
    next_xtalOff          = xtalOff;
    // counters run freely; fourCnt stays in step with the low bits of cycleCnt
    next_cycleCnt         = cycleEnd ? CNT_ZERO : cycleCnt + CNT_ONE;
    next_fourCnt          = fourCnt + 2'(1);
    if (wrPower) begin
      // switchback enable is written without restriction
      next_switchbackEnable = sfrWrData[BIT_SWITCHBACK];
      if (sfrWrData[BIT_DIV_HI:BIT_DIV_LO] == DIV_4) begin
        next_divSelect    = DIV_4;
        next_pendingApply = 1'b1;
      // reduced from 4 only
      // the running rate must be 4 as well, so a pending exit blocks re-entry
      end else if (sfrWrData[BIT_DIV_HI:BIT_DIV_LO] != DIV_RESERVED &&
                   divSelect == DIV_4 && divApplied == DIV_4) begin
        next_divSelect    = sfrWrData[BIT_DIV_HI:BIT_DIV_LO];
        next_pendingApply = 1'b1;
      end
      // any other code, 00 included, leaves the field as it was
      // crystal off needs ring
      if (!sfrWrData[BIT_XTAL_OFF]) begin
        // turning the amplifier back on is always allowed
        next_xtalOff = 1'b0;
      end else if (!srcSelect) begin
        next_xtalOff = 1'b1;
      end
    end
    // switchback touches divider only
    // a trigger beats a reduced-rate write in the same cycle
    if (hwSwitchback && next_divSelect != DIV_4) begin
      next_divSelect    = DIV_4;
      next_pendingApply = 1'b1;
    end
    // apply at cycle end
    // a write landing on this edge waits for the next boundary
    if (pendingApply && cycleEnd) begin
      next_divApplied   = divSelect;
      next_pendingApply = (next_divSelect != divSelect);
    end
  end

  // divider registers; clkEn low freezes the whole group
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // reset lands on the 4-clock rate with nothing pending
      divSelect        <= DIV_4;
      divApplied       <= DIV_4;
      pendingApply     <= 1'b0;
      cycleCnt         <= CNT_ZERO;
      fourCnt          <= 2'h0;
      switchbackEnable <= 1'b0;
      xtalOff          <= 1'b0;
    end else if (clkEn) begin
      divSelect        <= next_divSelect;
      divApplied       <= next_divApplied;
      pendingApply     <= next_pendingApply;
      cycleCnt         <= next_cycleCnt;
      fourCnt          <= next_fourCnt;
      switchbackEnable <= next_switchbackEnable;
      xtalOff          <= next_xtalOff;
    end
  end

  // clock source, crystal warm-up and source switch
  always_comb begin
    next_srcSelect = srcSelect;
    next_srcActive = srcActive;
    next_xtalReady = xtalReady;
    next_warmCnt   = warmCnt;
    if (wrFlags) begin
      if (!sfrWrData[BIT_SRC_SELECT]) begin
        // the ring may be chosen at any time
        next_srcSelect = 1'b0;
      end else if (xtalReady && !xtalOff) begin
        // the crystal only once it is powered and warm
        next_srcSelect = 1'b1;
      end
    end
    // warm-up counter; core clock stands in for crystal clocks
    // limitation: on a slow ring the warm-up lasts longer in time
    if (xtalOff) begin
      // amplifier off drops readiness and restarts the count
      next_xtalReady = 1'b0;
      next_warmCnt   = 17'h00000;
    end else if (!xtalReady) begin
      if (warmCnt >= 17'(WARMUP_CLOCKS - 1)) begin
        next_xtalReady = 1'b1;
      end else begin
        next_warmCnt = warmCnt + 17'h00001;
      end
    end
    // source change lands at cycle end, one cycle delay
    // independent of divider
    // swapping only at a boundary keeps a machine cycle from being cut short
    if (cycleEnd) begin
      next_srcActive = !srcSelect;
    end
  end

  // source registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // crystal selected and counted as ready out of reset
      srcSelect <= RST_SRC_SELECT;
      srcActive <= 1'b0;
      xtalReady <= RST_XTAL_READY;
      warmCnt   <= 17'h00000;
    end else if (clkEn) begin
      srcSelect <= next_srcSelect;
      srcActive <= next_srcActive;
      xtalReady <= next_xtalReady;
      warmCnt   <= next_warmCnt;
    end
  end

  // ticks and read data; reads have no side effects
  always_comb begin
    next_machineTick    = cycleEnd;
    // idle runs peripherals at divide four
    // fourCnt shares the phase of cycleCnt, so entering idle adds no short tick
    next_peripheralTick = idleMode ? (fourCnt == 2'(CLK_PER_CYCLE_4 - 1)) : cycleEnd;
    // a quiet bus reads zero, so a stray capture is harmless
    next_sfrRdData      = 8'h00;
    if (sfrRead) begin
      case (sfrAddr)
        ADDR_POWER_MGMT: begin
          // control fields read back as stored
          next_sfrRdData[BIT_DIV_HI:BIT_DIV_LO] = divSelect;
          next_sfrRdData[BIT_SWITCHBACK]        = switchbackEnable;
          next_sfrRdData[BIT_XTAL_OFF]          = xtalOff;
        end
        ADDR_EXT_INT_FLAGS: begin
          // selection and the source really in use
          next_sfrRdData[BIT_SRC_SELECT] = srcSelect;
          next_sfrRdData[BIT_SRC_STATUS] = srcActive;
        end
        ADDR_STATUS: begin
          // interrupt service levels and crystal ready
          next_sfrRdData[BIT_PF_SERVICE] = pfInService;
          next_sfrRdData[BIT_HI_SERVICE] = hiInService;
          next_sfrRdData[BIT_LO_SERVICE] = loInService;
          next_sfrRdData[BIT_XTAL_READY] = xtalReady;
          // serial activity arrives as {tx1, rx1, tx0, rx0}
          next_sfrRdData[BIT_TX1_ACTIVE] = serialActivity[3];
          next_sfrRdData[BIT_RX1_ACTIVE] = serialActivity[2];
          next_sfrRdData[BIT_TX0_ACTIVE] = serialActivity[1];
          next_sfrRdData[BIT_RX0_ACTIVE] = serialActivity[0];
        end
        // unmapped addresses read zero
        default: next_sfrRdData = 8'h00;
      endcase
    end
  end

  // output registers
  // outputs load the next values, so they match the internal state exactly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      machineTick    <= 1'b0;
      peripheralTick <= 1'b0;
      sfrRdData      <= 8'h00;
      ringSelected   <= 1'b0;
      crystalAmpOff  <= 1'b0;
      dividerActive  <= DIV_4;
    end else if (clkEn) begin
      machineTick    <= next_machineTick;
      peripheralTick <= next_peripheralTick;
      sfrRdData      <= next_sfrRdData;
      ringSelected   <= next_srcActive;
      crystalAmpOff  <= next_xtalOff;
      dividerActive  <= next_divApplied;
    end
  end

endmodule : pm_clock_divider

// *** rtl/pm_clock_pkg.sv ***
package pm_clock_pkg;
  // special-function register addresses
  localparam logic [7:0] ADDR_EXT_INT_FLAGS = 8'h91;
  localparam logic [7:0] ADDR_POWER_MGMT    = 8'hc4;
  localparam logic [7:0] ADDR_STATUS        = 8'hc5;
  // power_management field positions
  localparam int BIT_DIV_HI      = 7;
  localparam int BIT_DIV_LO      = 6;
  localparam int BIT_SWITCHBACK  = 5;
  localparam int BIT_XTAL_OFF    = 3;
  // external_int_flags field positions
  localparam int BIT_SRC_SELECT  = 3;
  localparam int BIT_SRC_STATUS  = 2;
  // status field positions
  localparam int BIT_PF_SERVICE  = 7;
  localparam int BIT_HI_SERVICE  = 6;
  localparam int BIT_LO_SERVICE  = 5;
  localparam int BIT_XTAL_READY  = 4;
  localparam int BIT_TX1_ACTIVE  = 3;
  localparam int BIT_RX1_ACTIVE  = 2;
  localparam int BIT_TX0_ACTIVE  = 1;
  localparam int BIT_RX0_ACTIVE  = 0;
  // divider codes
  localparam logic [1:0] DIV_RESERVED = 2'h0;
  localparam logic [1:0] DIV_4        = 2'h1;
  localparam logic [1:0] DIV_64       = 2'h2;
  localparam logic [1:0] DIV_1024     = 2'h3;
  // clocks per machine cycle
  localparam int CLK_PER_CYCLE_4    = 4;
  localparam int CLK_PER_CYCLE_64   = 64;
  localparam int CLK_PER_CYCLE_1024 = 1024;
  // crystal warm-up, in crystal clocks
  localparam int XTAL_WARMUP_CLOCKS = 65536;
  // reset values
  localparam logic       RST_SRC_SELECT = 1'b1;
  localparam logic       RST_XTAL_READY = 1'b1;
  localparam logic [9:0] CNT_ZERO       = 10'h000;
  localparam logic [9:0] CNT_ONE        = 10'h001;
endpackage : pm_clock_pkg

// *** verif/core_model.sv ***
`timescale 1ns/1ps
// core and serial side: one-cycle register strobes and trigger pulses
module core_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] sfrAddr,
  output logic      [7:0] sfrWrData,
  output logic            sfrWrite,
  output logic            sfrRead,
  input  wire logic [7:0] sfrRdData,
  // switchback triggers
  output logic            extIntTakeable,
  output logic            rxStartEdge,
  output logic            txBufferWrite
);
  initial {sfrAddr, sfrWrData, sfrWrite, sfrRead, extIntTakeable, rxStartEdge, txBufferWrite} = 21'h0;
  // write strobe for one cycle; data inverted after so it never lingers
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrite <= 1'b1;
    @(posedge clk);
    sfrWrite <= 1'b0;
    sfrWrData <= ~d;
  endtask : wr
  // read data is registered, so it is taken just after the strobe edge
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrRead <= 1'b1;
    @(posedge clk);
    sfrRead <= 1'b0;
    #1 d = sfrRdData;
  endtask : rd
  // pulse: 0 interrupt, 1 start bit, 2 transmit write
  task pulse(input int k);
    @(posedge clk);
    {txBufferWrite, rxStartEdge, extIntTakeable} <= 3'h1 << k;
    @(posedge clk);
    {txBufferWrite, rxStartEdge, extIntTakeable} <= 3'h0;
  endtask : pulse
endmodule : core_model

// *** verif/pm_clock_props.sv ***
`timescale 1ns/1ps
// watches the divider outputs against the register writes and triggers
module pm_clock_props
  import pm_clock_pkg::*;
#(
  parameter int WARMUP_CLOCKS = XTAL_WARMUP_CLOCKS
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // register port
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic       sfrWrite,
  input wire logic       sfrRead,
  input wire logic [7:0] sfrRdData,
  // core state and triggers
  input wire logic       idleMode,
  input wire logic       extIntTakeable,
  input wire logic       rxStartEdge,
  input wire logic       txBufferWrite,
  // clock tree
  input wire logic       machineTick,
  input wire logic       peripheralTick,
  input wire logic [1:0] dividerActive
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  logic [10:0] gap, next_gap;         // clocks since the last tick
  logic [1:0]  lastDiv, next_lastDiv; // divider of the running cycle
  logic        swbOn, next_swbOn;     // shadow of the switchback bit
  logic [10:0] swbWait, next_swbWait; // clocks a switchback has been owed
  // gap starts at -1 so the first cycle after reset also counts four
  always_comb begin
    next_gap     = machineTick ? 11'h000 : gap + 11'h001;
    next_lastDiv = machineTick ? dividerActive : lastDiv;
    next_swbOn   = (sfrWrite && sfrAddr == ADDR_POWER_MGMT) ? sfrWrData[BIT_SWITCHBACK] : swbOn;
    // count from an armed trigger until the 4-clock rate is in use
    next_swbWait = 11'h000;
    if (swbWait != 11'h000 && dividerActive != DIV_4) next_swbWait = swbWait + 11'h001;
    else if (swbOn && (extIntTakeable || rxStartEdge || txBufferWrite)) next_swbWait = 11'h001;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap <= 11'h7ff;
      lastDiv <= DIV_4;
      swbOn <= 1'b0;
      swbWait <= 11'h000;
    end else begin
      gap <= next_gap;
      lastDiv <= next_lastDiv;
      swbOn <= next_swbOn;
      swbWait <= next_swbWait;
    end
  end
  a_cycle_length: assert property (machineTick |-> gap == ((lastDiv == DIV_64) ? 11'h03f :
    (lastDiv == DIV_1024) ? 11'h3ff : 11'h003)) else $error("machine cycle length wrong");
  a_tick_spacing: assert property (machineTick |=> !machineTick [*3])
    else $error("machine ticks too close");
  a_reduced_from_four: assert property (dividerActive != $past(dividerActive) && dividerActive != DIV_4
    |-> $past(dividerActive) == DIV_4) else $error("reduced divider entered from reduced");
  a_never_reserved: assert property (dividerActive != DIV_RESERVED)
    else $error("reserved divider in use");
  a_idle_rate: assert property ((peripheralTick && idleMode) ##1 idleMode [*4] |-> peripheralTick)
    else $error("idle peripheral tick not every four");
  a_tick_follows: assert property (!idleMode && !$past(idleMode) |-> peripheralTick == machineTick)
    else $error("peripheral tick differs from machine tick");
  // worst case: one full slowest cycle after the trigger, plus the register
  a_switchback_bound: assert property (swbWait <= 11'(CLK_PER_CYCLE_1024 + 1))
    else $error("switchback missing");
  a_read_quiet: assert property (!$past(sfrRead) |-> sfrRdData == 8'h00)
    else $error("read data outside read cycle");
endmodule : pm_clock_props

bind pm_clock_divider pm_clock_props #(
  .WARMUP_CLOCKS  (WARMUP_CLOCKS)
) props_u (
  .clk            (clk),
  .arst_n         (arst_n),
  .sfrAddr        (sfrAddr),
  .sfrWrData      (sfrWrData),
  .sfrWrite       (sfrWrite),
  .sfrRead        (sfrRead),
  .sfrRdData      (sfrRdData),
  .idleMode       (idleMode),
  .extIntTakeable (extIntTakeable),
  .rxStartEdge    (rxStartEdge),
  .txBufferWrite  (txBufferWrite),
  .machineTick    (machineTick),
  .peripheralTick (peripheralTick),
  .dividerActive  (dividerActive)
);

// *** verif/testbench.sv ***
`timescale 1ns/1ps
// core model drives the registers; each task judges what comes back
module testbench
  import pm_clock_pkg::*;
;
  logic clk, arst_n, clkEn, idleMode, pfInService, hiInService, loInService;
  logic sfrWrite, sfrRead, extIntTakeable, rxStartEdge, txBufferWrite;
  logic machineTick, peripheralTick, ringSelected, crystalAmpOff;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, d;
  logic [3:0] serialActivity;
  logic [1:0] dividerActive;
  int n_mismatch = 0;
  int compares = 0;
  int n;
  // short warm-up keeps the crystal restart brief
  pm_clock_divider #(.WARMUP_CLOCKS(16)) dut_u (.*);
  core_model core_u (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task finish_test();
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task rc(input logic [7:0] a, input logic [7:0] e);
    core_u.rd(a, d);
    chk($sformatf("register %h", a), e, d);
  endtask : rc
  task pm(input logic [7:0] v);
    core_u.wr(ADDR_POWER_MGMT, v);
  endtask : pm
  // bounded wait for a divider code; running out ends the run
  task waitDiv(input logic [1:0] e, input int lim);
    // look just after each edge, once the registered code has settled
    for (int i = 0; i < lim && dividerActive !== e; i++) begin
      @(posedge clk);
      #1;
    end
    #1 chk("dividerActive", {6'h00, e}, {6'h00, dividerActive});
    if (dividerActive !== e) finish_test();
  endtask : waitDiv
  task ringChk(input logic e);
    #1 chk("ringSelected", {7'h00, e}, {7'h00, ringSelected});
  endtask : ringChk
  task testDivider();
    rc(ADDR_POWER_MGMT, 8'h40);
    rc(ADDR_EXT_INT_FLAGS, 8'h08);
    rc(ADDR_STATUS, 8'hb5);
    rc(8'h90, 8'h00);
    pm(8'h80);
    waitDiv(DIV_64, 6);
    pm(8'hc0);
    pm(8'h00);
    rc(ADDR_POWER_MGMT, 8'h80);
    pm(8'h40);
    waitDiv(DIV_4, 70);
    pm(8'hc0);
    waitDiv(DIV_1024, 6);
    pm(8'h40);
    waitDiv(DIV_4, 1030);
  endtask : testDivider
  task testSwitchback();
    for (int k = 0; k < 3; k++) begin
      pm(8'ha0);
      waitDiv(DIV_64, 6);
      core_u.pulse(k);
      waitDiv(DIV_4, 70);
      rc(ADDR_POWER_MGMT, 8'h60);
    end
    pm(8'h80);
    waitDiv(DIV_64, 6);
    core_u.pulse(0);
    rc(ADDR_POWER_MGMT, 8'h80);
    pm(8'h40);
    waitDiv(DIV_4, 70);
  endtask : testSwitchback
  task testSource();
    pm(8'h48);
    rc(ADDR_POWER_MGMT, 8'h40);
    chk("crystalAmpOff", 8'h00, {7'h00, crystalAmpOff});
    core_u.wr(ADDR_EXT_INT_FLAGS, 8'h00);
    repeat (6) @(posedge clk);
    ringChk(1'b1);
    pm(8'ha8);
    waitDiv(DIV_64, 6);
    rc(ADDR_STATUS, 8'ha5);
    chk("crystalAmpOff", 8'h01, {7'h00, crystalAmpOff});
    core_u.wr(ADDR_EXT_INT_FLAGS, 8'h08);
    rc(ADDR_EXT_INT_FLAGS, 8'h04);
    core_u.pulse(2);
    waitDiv(DIV_4, 70);
    ringChk(1'b1);
    pm(8'h40);
    repeat (20) @(posedge clk);
    rc(ADDR_STATUS, 8'hb5);
    chk("crystalAmpOff", 8'h00, {7'h00, crystalAmpOff});
    core_u.wr(ADDR_EXT_INT_FLAGS, 8'h08);
    repeat (6) @(posedge clk);
    ringChk(1'b0);
  endtask : testSource
  task testIdle();
    n = 0;
    pm(8'h80);
    waitDiv(DIV_64, 6);
    @(posedge clk);
    idleMode <= 1'b1;
    repeat (8) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      #1 n += int'(peripheralTick);
    end
    chk("peripheralTick count", 8'h0a, 8'(n));
    @(posedge clk);
    idleMode <= 1'b0;
    pm(8'h40);
    waitDiv(DIV_4, 70);
  endtask : testIdle
  initial begin
    {arst_n, idleMode, hiInService, clkEn, pfInService, loInService} = 6'h07;
    serialActivity = 4'h5;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    testDivider();
    testSwitchback();
    testSource();
    testIdle();
    finish_test();
  end
  // a hang counts as a mismatch
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule : testbench
